// File: bench/cache_param_leaf_assertions.sv
// Checker of cache leaf answers
`default_nettype none
module cache_param_leaf_assertions (
  // Watched ports
  input wire logic clk, rst_b, clk_en, query_valid, result_valid,
  input wire logic [31:0] leaf, sub_leaf_index, misc_enable_register,
  input wire logic [31:0] first_result_word, cache_set_count_word, reserved_result_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic take = query_valid && clk_en;
  sequence s_top;
    take && leaf == 32'h4 && sub_leaf_index == 32'h0 && !misc_enable_register[22];
  endsequence
  a_answer_next: assert property (take |=> result_valid)
    else $error("late");
  a_single_pulse: assert property (clk_en && !take |=> !result_valid)
    else $error("stray");
  a_words_hold: assert property (!take |=> $stable(first_result_word))
    else $error("moved");
  a_type_legal: assert property (result_valid |-> first_result_word[4:0] <= 5'h3)
    else $error("type");
  a_reserved_zero: assert property (result_valid |-> reserved_result_word == 32'h0
    && first_result_word[13:10] == 4'h0) else $error("reserved");
  a_hidden_zero: assert property (take && (leaf != 32'h4 || misc_enable_register[22])
    |=> cache_set_count_word == 32'h0) else $error("shown");
  a_first_word: assert property (s_top |=> first_result_word == 32'h0C004121)
    else $error("first");
  a_set_count: assert property (s_top |=> cache_set_count_word == 32'h3F)
    else $error("sets");
  a_freeze_hold: assert property (!clk_en |=> $stable(result_valid))
    else $error("frozen valid moved");
endmodule : cache_param_leaf_assertions
bind cache_param_leaf cache_param_leaf_assertions u_chk (.clk, .rst_b, .clk_en,
  .query_valid, .result_valid, .leaf, .sub_leaf_index, .misc_enable_register,
  .first_result_word, .cache_set_count_word, .reserved_result_word);
`default_nettype wire

// File: bench/cache_param_leaf_tb_top.sv
// Bench for the cache parameter leaf
`default_nettype none
module cache_param_leaf_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, query_valid = 1'b0, misc_enable_we = 1'b0;
  logic [31:0] leaf = 32'h0, sub_leaf_index = 32'h0, misc_enable_wdata = 32'h0;
  logic [31:0] misc_enable_register, first_result_word, second_result_word;
  logic [31:0] cache_set_count_word, reserved_result_word;
  logic result_valid;
  int mismatches = 0, samples_checked = 0;
  cache_param_leaf DUT (.clk, .rst_b, .clk_en, .query_valid, .leaf, .sub_leaf_index,
    .misc_enable_we, .misc_enable_wdata, .misc_enable_register, .result_valid,
    .first_result_word, .second_result_word, .cache_set_count_word, .reserved_result_word);
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  function automatic logic [31:0] size_of(input logic [31:0] w1, w2);
    size_of = (w1[31:22] + 32'h1) * (w1[21:12] + 32'h1) * (w1[11:0] + 32'h1) * (w2 + 32'h1);
  endfunction : size_of
  // Software choice of prefetch stride; zero means the size is ignored
  function automatic int stride(input logic [4:0] ct, input logic det, input int pf,
                                input logic [7:0] legacy);
    if (ct != 5'h01 && ct != 5'h03) stride = 0;
    else if (det && pf != 0) stride = pf;
    else if (det) stride = 64;
    else if (legacy == 8'hF0) stride = 64;
    else if (legacy == 8'hF1) stride = 128;
    else stride = 32;
  endfunction : stride
  task automatic q(input logic [31:0] lf, ix, e0, e1, e2);
    @(posedge clk) #1 query_valid = 1'b1;
    leaf = lf;
    sub_leaf_index = ix;
    @(posedge clk) #1 query_valid = 1'b0;
    chk(32'(result_valid), 32'h1);
    chk(first_result_word, e0);
    chk(second_result_word, e1);
    chk(cache_set_count_word, e2);
    chk(reserved_result_word, 32'h0);
    @(posedge clk) #1 chk(32'(result_valid), 32'h0);
    chk(first_result_word, e0);
  endtask : q
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(misc_enable_register, 32'h0);
    q(32'h4, 32'h0, 32'h0C004121, 32'h01C0003F, 32'h3F);
    chk(size_of(second_result_word, cache_set_count_word), 32'h0000_8000);
    chk(stride(first_result_word[4:0], 1'b1, 0, 8'h00), 32'h40);
    chk(stride(5'h02, 1'b1, 128, 8'h00), 32'h0);
    chk(stride(5'h03, 1'b1, 128, 8'h00), 32'h80);
    chk(stride(5'h01, 1'b0, 0, 8'hF0), 32'h40);
    chk(stride(5'h01, 1'b0, 0, 8'hF1), 32'h80);
    chk(stride(5'h01, 1'b0, 0, 8'h00), 32'h20);
    q(32'h4, 32'h1, 32'h0C004122, 32'h01C0003F, 32'h3F);
    q(32'h4, 32'h2, 32'h0C004143, 32'h01C0003F, 32'h1FF);
    q(32'h4, 32'h3, 32'h0C03C163, 32'h03C0003F, 32'h1FFF);
    clk_en = 1'b0;
    sub_leaf_index = 32'h0;
    query_valid = 1'b1;
    @(posedge clk) #1 query_valid = 1'b0;
    clk_en = 1'b1;
    chk(32'(result_valid), 32'h0);
    chk(cache_set_count_word, 32'h1FFF);
    q(32'h4, 32'h4, 32'h0, 32'h0, 32'h0);
    q(32'h3, 32'h0, 32'h0, 32'h0, 32'h0);
    misc_enable_we = 1'b1;
    misc_enable_wdata = 32'h0040_0000;
    @(posedge clk) #1 misc_enable_we = 1'b0;
    chk(misc_enable_register, 32'h0040_0000);
    q(32'h4, 32'h0, 32'h0, 32'h0, 32'h0);
    rst_b = 1'b0;
    @(posedge clk) #1 rst_b = 1'b1;
    chk(misc_enable_register, 32'h0);
    chk(32'(result_valid), 32'h0);
    q(32'h4, 32'h0, 32'h0C004121, 32'h01C0003F, 32'h3F);
    complete_run();
  end
  // Cut a hang short
  initial begin
    repeat (200) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : cache_param_leaf_tb_top
`default_nettype wire

// File: hw/cache_desc_rom.sv
// Constant table of cache descriptions addressed by sub-leaf index
`default_nettype none
module cache_desc_rom
  import cache_leaf_pkg::*;
(
  // Lookup
  input wire logic [31:0] index,
  output cache_leaf_pkg::cache_desc_t desc
);
  // ********************************
  // Table
  // ********************************
  // Example hierarchy; indices past the table read as the null type
  always_comb begin
    desc = '0;
    case (index)
      32'h0000_0000: desc = '{CTYPE_DATA, 3'h1, 1'b1, 1'b0, 12'h001, 6'h03,
                              12'h03F, 10'h000, 10'h007, 32'h0000_003F};
      32'h0000_0001: desc = '{CTYPE_INSN, 3'h1, 1'b1, 1'b0, 12'h001, 6'h03,
                              12'h03F, 10'h000, 10'h007, 32'h0000_003F};
      32'h0000_0002: desc = '{CTYPE_UNIFIED, 3'h2, 1'b1, 1'b0, 12'h001, 6'h03,
                              12'h03F, 10'h000, 10'h007, 32'h0000_01FF};
      32'h0000_0003: desc = '{CTYPE_UNIFIED, 3'h3, 1'b1, 1'b0, 12'h00F, 6'h03,
                              12'h03F, 10'h000, 10'h00F, 32'h0000_1FFF};
      default: desc = '0;
    endcase
  end
endmodule : cache_desc_rom
`default_nettype wire

// File: hw/cache_leaf_pkg.sv
// Package: constants and field layout of the cache parameter leaf
`default_nettype none
package cache_leaf_pkg;
  // ********************************
  // Query and visibility
  // ********************************
  localparam logic [31:0] DET_CACHE_LEAF = 32'h0000_0004;
  localparam logic [31:0] LEGACY_LEAF_MAX = 32'h0000_0003;
  localparam logic [31:0] EXT_LEAF_BASE = 32'h8000_0000;
  localparam int LEGACY_LIMIT_POS = 22;
  localparam logic [31:0] MISC_ENABLE_RESET = 32'h0000_0000;
  // ********************************
  // Field positions
  // ********************************
  localparam int TYPE_LSB = 0;
  localparam int LEVEL_LSB = 5;
  localparam int SELF_INIT_POS = 8;
  localparam int FULL_ASSOC_POS = 9;
  localparam int SHARE_LSB = 14;
  localparam int CORES_LSB = 26;
  localparam int LINE_LSB = 0;
  localparam int PART_LSB = 12;
  localparam int WAYS_LSB = 22;
  // ********************************
  // Cache types
  // ********************************
  localparam logic [4:0] CTYPE_NULL = 5'h00;
  localparam logic [4:0] CTYPE_DATA = 5'h01;
  localparam logic [4:0] CTYPE_INSN = 5'h02;
  localparam logic [4:0] CTYPE_UNIFIED = 5'h03;
  // ********************************
  // Table of described levels
  // ********************************
  localparam int NUM_CACHES = 4;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  typedef struct packed {
    logic [4:0] ctype;
    logic [2:0] level;
    logic self_init;
    logic full_assoc;
    logic [11:0] share_m1;
    logic [5:0] cores_m1;
    logic [11:0] line_m1;
    logic [9:0] part_m1;
    logic [9:0] ways_m1;
    logic [31:0] sets_m1;
  } cache_desc_t;
endpackage : cache_leaf_pkg
`default_nettype wire

// File: hw/cache_param_leaf.sv
// Answers the deterministic cache parameter identification query
`default_nettype none
module cache_param_leaf
  import cache_leaf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Query
  input wire logic query_valid,
  input wire logic [31:0] leaf,
  input wire logic [31:0] sub_leaf_index,
  // Misc enable register write port
  input wire logic misc_enable_we,
  input wire logic [31:0] misc_enable_wdata,
  output logic [31:0] misc_enable_register,
  // Result
  output logic result_valid,
  output logic [31:0] first_result_word,
  output logic [31:0] second_result_word,
  output logic [31:0] cache_set_count_word,
  output logic [31:0] reserved_result_word
);
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [31:0] misc;
    logic valid;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ********************************
  // Table
  // ********************************
  // Index passes unchanged; the table holds the whole hierarchy
  // Rows past the end of the table read as null
  cache_desc_t raw_desc;
  cache_desc_t desc;

  cache_desc_rom u_rom (
    .index(sub_leaf_index),
    .desc(raw_desc)
  );

  // ********************************
  // Visibility
  // ********************************
  // Middle range of basic leaves hides behind the legacy limit bit
  // Leaves at or above the extended base stay visible
  function automatic logic leaf_visible(
    input logic [31:0] lf,
    input logic [31:0] misc
  );
    logic above_legacy;
    logic below_ext;
    above_legacy = (lf > LEGACY_LEAF_MAX);
    below_ext = (lf < EXT_LEAF_BASE);
    leaf_visible = !(above_legacy && below_ext && misc[LEGACY_LIMIT_POS]);
  endfunction : leaf_visible

  // ********************************
  // Row cleanup
  // ********************************
  // Types above unified are reserved and never handed out
  function automatic logic type_reserved(
    input logic [4:0] ctype
  );
    type_reserved = (ctype > CTYPE_UNIFIED);
  endfunction : type_reserved

  // Null or reserved row cleared whole, so a table slip cannot leak fields
  function automatic cache_desc_t clean_row(
    input cache_desc_t d
  );
    clean_row = d;
    if (d.ctype == CTYPE_NULL || type_reserved(d.ctype)) begin
      clean_row = '0;
    end
  endfunction : clean_row

  // ********************************
  // Packing
  // ********************************
  // Counts travel stored minus one, exactly as the table holds them
  // Type, level, flags and sharing counts
  function automatic logic [31:0] pack_first(
    input cache_desc_t d
  );
    logic [31:0] w;
    w = RESULT_RESET;
    w[TYPE_LSB +: 5] = d.ctype;
    w[LEVEL_LSB +: 3] = d.level;
    w[SELF_INIT_POS] = d.self_init;
    w[FULL_ASSOC_POS] = d.full_assoc;
    w[SHARE_LSB +: 12] = d.share_m1;
    w[CORES_LSB +: 6] = d.cores_m1;
    pack_first = w;
  endfunction : pack_first

  // Line size, partitions and ways
  function automatic logic [31:0] pack_second(
    input cache_desc_t d
  );
    logic [31:0] w;
    w = RESULT_RESET;
    w[LINE_LSB +: 12] = d.line_m1;
    w[PART_LSB +: 10] = d.part_m1;
    w[WAYS_LSB +: 10] = d.ways_m1;
    pack_second = w;
  endfunction : pack_second

  // Sets fill the whole word
  function automatic logic [31:0] pack_sets(
    input cache_desc_t d
  );
    pack_sets = d.sets_m1;
  endfunction : pack_sets

  // ********************************
  // Decode
  // ********************************
  logic det_leaf;
  logic visible;
  logic answer_hit;
  logic [31:0] misc_next;

  // Visibility reads the stored limit bit; a write in the same cycle acts later
  assign det_leaf = (leaf == DET_CACHE_LEAF);
  assign visible = leaf_visible(leaf, s_q.misc);
  assign answer_hit = det_leaf && visible;
  assign desc = clean_row(raw_desc);
  // Plain read/write word; only the limit bit steers the answer
  assign misc_next = misc_enable_we ? misc_enable_wdata : s_q.misc;

  // ********************************
  // Answer words
  // ********************************
  logic [31:0] first_next;
  logic [31:0] second_next;
  logic [31:0] sets_next;
  logic [31:0] reserved_next;

  // Hidden or foreign leaf answers all zero, read as null type
  assign first_next = answer_hit ? pack_first(desc) : RESULT_RESET;
  assign second_next = answer_hit ? pack_second(desc) : RESULT_RESET;
  assign sets_next = answer_hit ? pack_sets(desc) : RESULT_RESET;
  // Reserved word is zero for every index
  assign reserved_next = RESULT_RESET;

  // ********************************
  // Next state
  // ********************************
  // Valid is a one-cycle pulse per taken query
  always_comb begin
    s_d = s_q;
    s_d.misc = misc_next;
    s_d.valid = 1'b0;
    if (query_valid) begin
      s_d.valid = 1'b1;
      s_d.w0 = first_next;
      s_d.w1 = second_next;
      s_d.w2 = sets_next;
      s_d.w3 = reserved_next;
    end
  end

  // ********************************
  // Registers
  // ********************************
  // Only constants on the reset path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.misc <= MISC_ENABLE_RESET;
      s_q.valid <= 1'b0;
      s_q.w0 <= RESULT_RESET;
      s_q.w1 <= RESULT_RESET;
      s_q.w2 <= RESULT_RESET;
      s_q.w3 <= RESULT_RESET;
    end else if (clk_en) begin
      // Enable low freezes everything; a held query is simply not taken
      s_q <= s_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // Every output straight from a flop
  assign misc_enable_register = s_q.misc;
  assign result_valid = s_q.valid;
  assign first_result_word = s_q.w0;
  assign second_result_word = s_q.w1;
  assign cache_set_count_word = s_q.w2;
  assign reserved_result_word = s_q.w3;

endmodule : cache_param_leaf
`default_nettype wire
